// ---- core/tlp_pkg.sv ----
package tlp_pkg;
   // register and field layout of the staging pair
   localparam int REG_W = 64;
   localparam int VICTIM_W = 32;
   localparam int GLOBAL_BIT = 0;
   localparam int VALID_BIT = 1;
   localparam int WRITE_BIT = 2;
   localparam int COH_LO = 3;
   localparam int COH_HI = 5;
   localparam int FRAME_LO = 6;
   localparam int FRAME_HI = 29;
   localparam int EXT_LO = 30;
   localparam int EXT_HI = 54;
   localparam int FRAME_W = FRAME_HI - FRAME_LO + 1;
   localparam int EXT_W = EXT_HI - EXT_LO + 1;
   localparam int PA_MAX_LARGE = 59;
   localparam int PA_MAX_R1 = 36;
   localparam int PA_MAX_SMALL = 34;
   localparam int SMALL_SHIFT = 2;
   localparam int PAGE_SHIFT = 12;
   // coherency encodings that must work
   localparam logic [2:0] COH_UNCACHED = 3'h2;
   localparam logic [2:0] COH_CACHED = 3'h3;
   // register selectors on the move port
   localparam logic [1:0] SEL_VICTIM = 2'h0;
   localparam logic [1:0] SEL_EVEN = 2'h1;
   localparam logic [1:0] SEL_ODD = 2'h2;
   localparam logic [1:0] SEL_NONE = 2'h3;
   typedef enum logic [1:0] {TLP_IDLE, TLP_AERR} tlp_state_e;
endpackage

// ---- core/tlp_victim.sv ----
`timescale 1ns/1ps
`default_nettype none
module tlp_victim #(
   parameter int ENTRIES = 48,
   parameter int IDX_W = 6
) (
   input wire logic clk_sys_in,
   input wire logic arst_n_in,
   input wire logic wired_write_in,
   input wire logic [IDX_W-1:0] wired_count_in,
   input wire logic advance_in,
   output logic [IDX_W-1:0] victim_out
);
   import tlp_pkg::*;
   localparam logic [IDX_W-1:0] TOP = IDX_W'(ENTRIES - 1);
   logic [IDX_W-1:0] victim_q;
   logic [IDX_W-1:0] victim_d;

   initial begin
      if (ENTRIES < 2 || (1 << IDX_W) < ENTRIES)
         $error("index width cannot hold entry count");
   end

   // count down, wrap from wired floor back to top
   always_comb begin
      victim_d = victim_q;
      if (wired_write_in) begin
         victim_d = TOP;
      end else if (advance_in) begin
         if (victim_q <= wired_count_in || victim_q > TOP)
            victim_d = TOP;
         else
            victim_d = victim_q - IDX_W'(1);
      end
   end

   // reset loads the upper bound
   always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in)
         victim_q <= TOP;
      else
         victim_q <= victim_d;
   end

   assign victim_out = victim_q;

   chk_victim_bounds: assert property (@(posedge clk_sys_in)
      disable iff (!arst_n_in)
      (victim_q <= TOP) && (victim_q >= wired_count_in || $past(wired_write_in)
      || victim_q == TOP)) else $error("victim index out of range");
   chk_wired_reload: assert property (@(posedge clk_sys_in)
      disable iff (!arst_n_in)
      wired_write_in |=> victim_q == TOP) else $error("wired write did not reload");
endmodule
`default_nettype wire

// ---- core/tlp_regs.sv ----
`timescale 1ns/1ps
`default_nettype none
// Operation
// - victim index reads zero above the index field; upper writes ignored
// - victim index loads its upper bound at reset and on wired writes
// - victim index stays between wired count and entries minus one
// - after an address error both registers may be altered by hardware
// - high register writes do not update bad-address or context fields
// - fill bits above the implemented width ignore writes, read zero
// - first release frame field bits 29..6 maps address bits width-1..12
// - coherency field 5..3 supports encodings 2 and 3 at least
// - write-permit zero makes stores raise a modified fault
// - valid zero makes any access raise an invalid fault
// - TLB write stores AND of both global bits
// - global entries skip address space tag comparison
// - TLB read copies entry global bit into both registers
// - large addresses concatenate extension 54..30 with frame field
// - extension ignores writes, reads zero unless large addresses enabled
// - small pages map 33..10 shifted by two, otherwise 35..12
// - first release limits width to 36 bits and has no small pages
// - narrow widths let fill displace extension, frame top drops per bit
module tlp_regs #(
   parameter int PA_BITS = 36,
   parameter int RELEASE2 = 1,
   parameter int ENTRIES = 48,
   parameter int IDX_W = 6,
   parameter int ADDRESS_SPACE_TAG_W = 8
) (
   input wire logic clk_sys_in,
   input wire logic arst_n_in,
   // coprocessor move port
   input wire logic mov_wr_in,
   input wire logic [1:0] mov_sel_in,
   input wire logic [tlp_pkg::REG_W-1:0] mov_wdata_in,
   output logic [tlp_pkg::REG_W-1:0] mov_rdata_out,
   // mode inputs from configuration registers
   input wire logic large_addr_capable_in,
   input wire logic large_addr_enable_in,
   input wire logic small_page_capable_in,
   input wire logic small_page_enable_in,
   input wire logic wired_write_in,
   input wire logic [IDX_W-1:0] wired_count_in,
   input wire logic addr_error_in,
   // entry array side
   input wire logic tlb_write_in,
   input wire logic tlb_write_victim_in,
   output logic [tlp_pkg::REG_W-1:0] ent_even_out,
   output logic [tlp_pkg::REG_W-1:0] ent_odd_out,
   output logic ent_global_out,
   output logic [IDX_W-1:0] victim_idx_out,
   input wire logic tlb_read_in,
   input wire logic [tlp_pkg::REG_W-1:0] rd_even_in,
   input wire logic [tlp_pkg::REG_W-1:0] rd_odd_in,
   input wire logic rd_global_in,
   // translation check on a matched entry
   input wire logic chk_req_in,
   input wire logic chk_store_in,
   input wire logic chk_odd_in,
   input wire logic [ADDRESS_SPACE_TAG_W-1:0] chk_tag_in,
   input wire logic [ADDRESS_SPACE_TAG_W-1:0] cur_tag_in,
   output logic tag_match_out,
   output logic fault_invalid_out,
   output logic fault_modified_out,
   output logic [tlp_pkg::PA_MAX_LARGE-1:0] phys_page_out
);
   import tlp_pkg::*;

   logic [REG_W-1:0] even_q;
   logic [REG_W-1:0] odd_q;
   logic [REG_W-1:0] wmask;
   logic [REG_W-1:0] rmask_even;
   logic [REG_W-1:0] rmask_odd;
   logic large_on;
   logic small_on;
   logic [IDX_W-1:0] victim;
   tlp_state_e state_q;
   logic inv_q;
   logic mod_q;
   logic match_q;
   logic [PA_MAX_LARGE-1:0] page_q;
   logic [REG_W-1:0] half;
   logic [FRAME_W+EXT_W-1:0] page_frame_field;

   initial begin
      if (RELEASE2 == 0 && PA_BITS > PA_MAX_R1)
         $error("first release limits address width");
      if (PA_BITS > PA_MAX_LARGE || PA_BITS <= PAGE_SHIFT)
         $error("unsupported address width");
   end

   // enables; first release never has small pages or extension
   assign large_on = (RELEASE2 != 0) && large_addr_capable_in && large_addr_enable_in;
   assign small_on = (RELEASE2 != 0) && small_page_capable_in && small_page_enable_in;

   // writable bit mask as a function of width and modes
   function automatic logic [REG_W-1:0] frame_mask(input logic lg, input logic sm);
      int top;
      logic [REG_W-1:0] m;
      m = '0;
      top = sm ? (PA_BITS - PAGE_SHIFT + SMALL_SHIFT) : (PA_BITS - PAGE_SHIFT);
      if (!lg && top > FRAME_W)
         top = FRAME_W;
      if (top > FRAME_W + EXT_W)
         top = FRAME_W + EXT_W;
      for (int i = 0; i < FRAME_W + EXT_W; i++)
         if (i < top)
            m[FRAME_LO + i] = 1'b1;
      m[COH_HI:GLOBAL_BIT] = '1;
      return m;
   endfunction

   assign wmask = frame_mask(large_on, small_on);

   // write merge keeps fill bits at zero
   function automatic logic [REG_W-1:0] merge(input logic [REG_W-1:0] v,
                                             input logic [REG_W-1:0] m);
      return v & m;
   endfunction

   // even page register
   always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in)
         even_q <= '0;
      else if (tlb_read_in) begin
         even_q <= merge(rd_even_in, wmask);
         even_q[GLOBAL_BIT] <= rd_global_in;
      end else if (mov_wr_in && mov_sel_in == SEL_EVEN)
         even_q <= merge(mov_wdata_in, wmask);
   end

   // odd page register
   always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in)
         odd_q <= '0;
      else if (tlb_read_in) begin
         odd_q <= merge(rd_odd_in, wmask);
         odd_q[GLOBAL_BIT] <= rd_global_in;
      end else if (mov_wr_in && mov_sel_in == SEL_ODD)
         odd_q <= merge(mov_wdata_in, wmask);
   end

   // address error marks contents undefined; hardware leaves them untouched
   always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in)
         state_q <= TLP_IDLE;
      else if (addr_error_in)
         state_q <= TLP_AERR;
      else if (mov_wr_in && mov_sel_in != SEL_VICTIM && mov_sel_in != SEL_NONE)
         state_q <= TLP_IDLE;
   end

   tlp_victim #(
      .ENTRIES(ENTRIES),
      .IDX_W(IDX_W)
   ) u_victim (
      .clk_sys_in(clk_sys_in),
      .arst_n_in(arst_n_in),
      .wired_write_in(wired_write_in),
      .wired_count_in(wired_count_in),
      .advance_in(tlb_write_victim_in),
      .victim_out(victim)
   );

   // read masks hide extension when large addresses are off
   assign rmask_even = wmask;
   assign rmask_odd = wmask;

   // read mux; victim zero-extended above its index field
   always_comb begin
      case (mov_sel_in)
         SEL_VICTIM: mov_rdata_out = REG_W'(victim);
         SEL_EVEN: mov_rdata_out = even_q & rmask_even;
         SEL_ODD: mov_rdata_out = odd_q & rmask_odd;
         default: mov_rdata_out = '0;
      endcase
   end

   // entry write values; high register writes do not touch anything here
   assign ent_even_out = even_q & rmask_even;
   assign ent_odd_out = odd_q & rmask_odd;
   assign ent_global_out = even_q[GLOBAL_BIT] & odd_q[GLOBAL_BIT];
   assign victim_idx_out = victim;

   // selected half and its implemented frame bits
   assign half = chk_odd_in ? odd_q : even_q;
   assign page_frame_field = half[EXT_HI:FRAME_LO] & wmask[EXT_HI:FRAME_LO];

   // translation check of the selected half
   always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         inv_q <= 1'b0;
         mod_q <= 1'b0;
         match_q <= 1'b0;
         page_q <= '0;
      end else if (chk_req_in) begin
         match_q <= ent_global_out || (chk_tag_in == cur_tag_in);
         inv_q <= !half[VALID_BIT];
         mod_q <= half[VALID_BIT] && chk_store_in && !half[WRITE_BIT];
         if (small_on)
            page_q <= PA_MAX_LARGE'(page_frame_field) << (PAGE_SHIFT - SMALL_SHIFT);
         else
            page_q <= PA_MAX_LARGE'(page_frame_field) << PAGE_SHIFT;
      end else begin
         inv_q <= 1'b0;
         mod_q <= 1'b0;
      end
   end

   // coherency bits stored as written; encodings 2 and 3 always pass through
   assign tag_match_out = match_q;
   assign fault_invalid_out = inv_q;
   assign fault_modified_out = mod_q;
   assign phys_page_out = page_q;

   // a cleared even global bit clears the entry's global bit
   chk_global_and: assert property (@(posedge clk_sys_in)
      disable iff (!arst_n_in)
      mov_wr_in && mov_sel_in == SEL_EVEN && !tlb_read_in && !mov_wdata_in[GLOBAL_BIT]
      |=> !ent_global_out) else $error("global bit not AND of pair");
   // a TLB read copies the entry global bit into both halves
   chk_read_global: assert property (@(posedge clk_sys_in)
      disable iff (!arst_n_in)
      tlb_read_in |=> even_q[GLOBAL_BIT] == $past(rd_global_in)
      && odd_q[GLOBAL_BIT] == $past(rd_global_in)) else $error("read global lost");
   // a TLB read loads the even half from the even entry word
   chk_read_even: assert property (@(posedge clk_sys_in)
      disable iff (!arst_n_in)
      tlb_read_in |=> even_q[COH_HI:VALID_BIT] == $past(rd_even_in[COH_HI:VALID_BIT]))
      else $error("read even half lost");
   // an even move write never leaves fill bits set
   chk_fill_zero: assert property (@(posedge clk_sys_in)
      disable iff (!arst_n_in)
      mov_wr_in && mov_sel_in == SEL_EVEN && !tlb_read_in |=> (even_q & ~$past(wmask)) == '0)
      else $error("fill bits not zero");
   // extension hidden on read while large addresses are off
   chk_ext_off: assert property (@(posedge clk_sys_in)
      disable iff (!arst_n_in)
      !large_on |-> mov_rdata_out[EXT_HI:EXT_LO] == '0) else $error("extension visible");
   // extension dropped on write while large addresses are off
   chk_ext_write: assert property (@(posedge clk_sys_in)
      disable iff (!arst_n_in)
      mov_wr_in && mov_sel_in == SEL_EVEN && !large_on && !tlb_read_in
      |=> even_q[EXT_HI:EXT_LO] == '0) else $error("extension stored");
   // victim index reads zero above its field
   chk_victim_upper: assert property (@(posedge clk_sys_in)
      disable iff (!arst_n_in)
      mov_sel_in == SEL_VICTIM |-> mov_rdata_out[REG_W-1:IDX_W] == '0)
      else $error("victim upper bits set");
   // victim index ignores move writes
   chk_victim_ignore: assert property (@(posedge clk_sys_in)
      disable iff (!arst_n_in)
      mov_wr_in && mov_sel_in == SEL_VICTIM && !tlb_write_victim_in && !wired_write_in
      |=> $stable(victim_idx_out)) else $error("victim index written");
   // invalid half faults any access
   chk_invalid_fault: assert property (@(posedge clk_sys_in)
      disable iff (!arst_n_in)
      chk_req_in && !half[VALID_BIT] |=> fault_invalid_out)
      else $error("invalid fault missing");
   // store to a valid read-only half faults
   chk_modified_fault: assert property (@(posedge clk_sys_in)
      disable iff (!arst_n_in)
      chk_req_in && chk_store_in && half[VALID_BIT] && !half[WRITE_BIT] |=> fault_modified_out)
      else $error("modified fault missing");
   // store to a writable half passes
   chk_store_allowed: assert property (@(posedge clk_sys_in)
      disable iff (!arst_n_in)
      chk_req_in && half[VALID_BIT] && half[WRITE_BIT] |=> !fault_modified_out)
      else $error("store refused");
   // faults stand for one cycle per check
   chk_fault_pulse: assert property (@(posedge clk_sys_in)
      disable iff (!arst_n_in)
      !chk_req_in |=> !fault_invalid_out && !fault_modified_out)
      else $error("fault held too long");
   // global entries match whatever the tag
   chk_global_match: assert property (@(posedge clk_sys_in)
      disable iff (!arst_n_in)
      chk_req_in && ent_global_out |=> tag_match_out) else $error("global entry missed");
   // private entries with another tag miss
   chk_tag_miss: assert property (@(posedge clk_sys_in)
      disable iff (!arst_n_in)
      chk_req_in && !ent_global_out && chk_tag_in != cur_tag_in |=> !tag_match_out)
      else $error("foreign tag matched");
   // even and odd move writes land in their own halves
   chk_even_write: assert property (@(posedge clk_sys_in)
      disable iff (!arst_n_in)
      mov_wr_in && mov_sel_in == SEL_EVEN && !tlb_read_in |=> even_q[COH_HI:GLOBAL_BIT]
      == $past(mov_wdata_in[COH_HI:GLOBAL_BIT])) else $error("even write lost");
   chk_odd_write: assert property (@(posedge clk_sys_in)
      disable iff (!arst_n_in)
      mov_wr_in && mov_sel_in == SEL_ODD && !tlb_read_in |=> odd_q[COH_HI:GLOBAL_BIT]
      == $past(mov_wdata_in[COH_HI:GLOBAL_BIT])) else $error("odd write lost");
   // address error leaves the pair as it was
   chk_aerr_keep: assert property (@(posedge clk_sys_in)
      disable iff (!arst_n_in)
      addr_error_in && !mov_wr_in && !tlb_read_in |=> $stable(even_q) && $stable(odd_q))
      else $error("pair altered on address error");

   // main scenarios
   cov_tlb_read: cover property (@(posedge clk_sys_in) tlb_read_in);
   cov_fault: cover property (@(posedge clk_sys_in) fault_modified_out);
   cov_large: cover property (@(posedge clk_sys_in) large_on && mov_wr_in);
   cov_addr_error: cover property (@(posedge clk_sys_in) state_q == TLP_AERR);
   cov_entry_write: cover property (@(posedge clk_sys_in) tlb_write_in);
endmodule
`default_nettype wire

// ---- dv/tlp_core_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module tlp_core_model (
   input wire logic clk_sys_in,
   input wire logic arst_n_in,
   input wire logic tlb_write_in,
   input wire logic [tlp_pkg::REG_W-1:0] even_in,
   input wire logic [tlp_pkg::REG_W-1:0] odd_in,
   input wire logic global_in,
   output logic [tlp_pkg::REG_W-1:0] rd_even_out,
   output logic [tlp_pkg::REG_W-1:0] rd_odd_out,
   output logic rd_global_out
);
   import tlp_pkg::*;
   // one array entry, filled by a TLB write and offered back on a TLB read
   always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         rd_even_out <= '0;
         rd_odd_out <= '0;
         rd_global_out <= 1'h0;
      end else if (tlb_write_in) begin
         rd_even_out <= even_in; // even page half
         rd_odd_out <= odd_in; // odd page half
         rd_global_out <= global_in; // one global bit per entry
      end
   end
endmodule
`default_nettype wire

// ---- dv/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import tlp_pkg::*;
   logic clk_sys_in = '0, arst_n_in = '0, mov_wr_in = '0, rd_global_in, ent_global_out;
   logic [1:0] mov_sel_in = SEL_NONE;
   logic [REG_W-1:0] mov_wdata_in = '0, mov_rdata_out, ent_even_out, ent_odd_out;
   logic [REG_W-1:0] rd_even_in, rd_odd_in;
   logic large_addr_capable_in = '0, large_addr_enable_in = '0, small_page_capable_in = '0;
   logic small_page_enable_in = '0, wired_write_in = '0, addr_error_in = '0, tlb_write_in = '0;
   logic tlb_write_victim_in = '0, tlb_read_in = '0, chk_req_in = '0, chk_store_in = '0;
   logic chk_odd_in = '0, tag_match_out, fault_invalid_out, fault_modified_out;
   logic [5:0] wired_count_in = '0, victim_idx_out;
   logic [7:0] chk_tag_in = '0, cur_tag_in = '0;
   logic [PA_MAX_LARGE-1:0] phys_page_out;
   int bad_count = 0, compares = 0, cycles = 0;
   // 40 MHz clock
   always #12.5 clk_sys_in = ~clk_sys_in;
   // wide address so the extension field exists
   tlp_regs #(.PA_BITS(40), .RELEASE2(1), .ENTRIES(48), .IDX_W(6), .ADDRESS_SPACE_TAG_W(8)) u_tlp_regs (
      .clk_sys_in, .arst_n_in, .mov_wr_in, .mov_sel_in, .mov_wdata_in, .mov_rdata_out,
      .large_addr_capable_in, .large_addr_enable_in, .small_page_capable_in,
      .small_page_enable_in, .wired_write_in, .wired_count_in, .addr_error_in, .tlb_write_in,
      .tlb_write_victim_in, .ent_even_out, .ent_odd_out, .ent_global_out, .victim_idx_out,
      .tlb_read_in, .rd_even_in, .rd_odd_in, .rd_global_in, .chk_req_in, .chk_store_in,
      .chk_odd_in, .chk_tag_in, .cur_tag_in, .tag_match_out, .fault_invalid_out,
      .fault_modified_out, .phys_page_out
   );
   // entry array on the far side
   tlp_core_model u_tlp_core_model (
      .clk_sys_in, .arst_n_in, .tlb_write_in, .even_in(ent_even_out), .odd_in(ent_odd_out),
      .global_in(ent_global_out), .rd_even_out(rd_even_in), .rd_odd_out(rd_odd_in),
      .rd_global_out(rd_global_in)
   );
   task automatic wrap_up();
      $display("compares %0d bad_count %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic check(input logic [REG_W-1:0] seen, input logic [REG_W-1:0] exp);
      compares++;
      if (seen !== exp) begin
         bad_count++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic cb(input logic seen, input logic exp);
      check({63'h0, seen}, {63'h0, exp});
   endtask
   // one move write, taken at the second edge
   task automatic wr(input logic [1:0] sel, input logic [REG_W-1:0] d);
      @(posedge clk_sys_in);
      mov_wr_in <= 1'h1;
      mov_sel_in <= sel;
      mov_wdata_in <= d;
      @(posedge clk_sys_in);
      mov_wr_in <= 1'h0;
   endtask
   // combinational read, sampled mid-cycle
   task automatic rdchk(input logic [1:0] sel, input logic [REG_W-1:0] exp);
      @(posedge clk_sys_in);
      mov_sel_in <= sel;
      @(negedge clk_sys_in);
      check(mov_rdata_out, exp);
   endtask
   // one victim advance, then the new index
   task automatic adv(input logic [5:0] exp);
      @(posedge clk_sys_in);
      tlb_write_victim_in <= 1'h1;
      @(posedge clk_sys_in);
      tlb_write_victim_in <= 1'h0;
      @(negedge clk_sys_in);
      check({58'h0, victim_idx_out}, {58'h0, exp});
   endtask
   // one translation check, outputs a cycle later
   task automatic chk(input logic st, input logic od, input logic [7:0] tag);
      @(posedge clk_sys_in);
      chk_req_in <= 1'h1;
      chk_store_in <= st;
      chk_odd_in <= od;
      chk_tag_in <= tag;
      @(posedge clk_sys_in);
      chk_req_in <= 1'h0;
      @(negedge clk_sys_in);
   endtask
   task automatic t_reset();
      check({58'h0, victim_idx_out}, 64'h2F);
      rdchk(SEL_VICTIM, 64'h2F);
      rdchk(SEL_EVEN, '0);
   endtask
   // width probe in each mode: lcap, len, scap, sen
   task automatic t_width();
      logic [3:0] md [5] = '{4'h0, 4'h4, 4'h3, 4'hC, 4'hF};
      logic [REG_W-1:0] mk [5] = '{64'h3FFFFFFF, 64'h3FFFFFFF, 64'h3FFFFFFF, 64'h3FFFFFFFF,
                                   64'hFFFFFFFFF};
      for (int i = 0; i < 6; i++) begin
         wr(SEL_EVEN, '0);
         wr(SEL_ODD, '0);
         {large_addr_capable_in, large_addr_enable_in, small_page_capable_in,
          small_page_enable_in} <= (i < 5) ? md[i] : 4'h0;
         if (i < 5) begin
            wr(SEL_EVEN, '1);
            rdchk(SEL_EVEN, mk[i]);
         end
      end
      wr(SEL_ODD, '1);
      rdchk(SEL_ODD, 64'h3FFFFFFF);
      rdchk(SEL_EVEN, '0);
   endtask
   task automatic t_victim();
      adv(6'h2E);
      @(posedge clk_sys_in);
      wired_count_in <= 6'h2D;
      wired_write_in <= 1'h1;
      @(posedge clk_sys_in);
      wired_write_in <= 1'h0;
      adv(6'h2E);
      adv(6'h2D);
      adv(6'h2F);
      wr(SEL_VICTIM, '1);
      rdchk(SEL_VICTIM, 64'h2F);
   endtask
   // staging to the entry array and back
   task automatic t_entry();
      wr(SEL_EVEN, 64'h48D159F);
      wr(SEL_ODD, 64'h16);
      @(negedge clk_sys_in);
      check(ent_even_out, 64'h48D159F);
      check(ent_odd_out, 64'h16);
      cb(ent_global_out, 1'h0);
      @(posedge clk_sys_in);
      tlb_write_in <= 1'h1;
      @(posedge clk_sys_in);
      tlb_write_in <= 1'h0;
      wr(SEL_ODD, 64'h17);
      rdchk(SEL_ODD, 64'h17);
      cb(ent_global_out, 1'h1);
      @(posedge clk_sys_in);
      tlb_read_in <= 1'h1;
      @(posedge clk_sys_in);
      tlb_read_in <= 1'h0;
      rdchk(SEL_EVEN, 64'h48D159E);
      rdchk(SEL_ODD, 64'h16);
   endtask
   task automatic t_check();
      @(posedge clk_sys_in);
      cur_tag_in <= 8'h5A;
      wr(SEL_EVEN, 64'h48D159A);
      wr(SEL_ODD, 64'h14);
      chk(1'h1, 1'h0, 8'h3C);
      cb(fault_modified_out, 1'h1);
      cb(fault_invalid_out, 1'h0);
      cb(tag_match_out, 1'h0);
      check({5'h0, phys_page_out}, 64'h123456000);
      chk(1'h0, 1'h0, 8'h3C);
      cb(fault_modified_out, 1'h0);
      chk(1'h0, 1'h1, 8'h5A);
      cb(fault_invalid_out, 1'h1);
      cb(tag_match_out, 1'h1);
      wr(SEL_EVEN, 64'h48D159B);
      wr(SEL_ODD, 64'h15);
      chk(1'h0, 1'h0, 8'h3C);
      cb(tag_match_out, 1'h1);
      cb(fault_invalid_out, 1'h0);
      @(posedge clk_sys_in);
      addr_error_in <= 1'h1;
      @(posedge clk_sys_in);
      addr_error_in <= 1'h0;
      rdchk(SEL_EVEN, 64'h48D159B);
   endtask
   // page base in small-page and large-address modes
   task automatic t_modes();
      wr(SEL_EVEN, '0);
      wr(SEL_ODD, '0);
      {small_page_capable_in, small_page_enable_in} <= 2'h3;
      wr(SEL_EVEN, 64'h48D159F);
      chk(1'h1, 1'h0, 8'h5A);
      cb(fault_modified_out, 1'h0);
      check({5'h0, phys_page_out}, 64'h48D15800);
      wr(SEL_EVEN, '0);
      {large_addr_capable_in, large_addr_enable_in, small_page_capable_in,
       small_page_enable_in} <= 4'hC;
      wr(SEL_EVEN, 64'h300000042);
      chk(1'h0, 1'h0, 8'h5A);
      check({5'h0, phys_page_out}, 64'hC000001000);
   endtask
   // cycle ceiling against hangs
   always @(posedge clk_sys_in) begin
      cycles++;
      if (cycles == 5000) begin
         bad_count++;
         wrap_up();
      end
   end
   // main sequence
   initial begin
      repeat (10) @(posedge clk_sys_in);
      arst_n_in <= 1'h1;
      @(negedge clk_sys_in);
      t_reset();
      t_width();
      t_victim();
      t_entry();
      t_check();
      t_modes();
      wrap_up();
   end
endmodule
`default_nettype wire
